// file: src/dsw_receiver.v
// Contract
// - With frame select low, sample data on each serial clock fall into 16-bit register
// - After 16 or more falls, frame select rise commits word and updates outputs
// - Frame select rise before sixteenth fall aborts; word discarded, no state change
// - Chain output passes shifted-out bits; valid only after more than 16 clocks
// - Committed word selects mode, power-down and channel register or output value
// - After reset all channel outputs stay zero until first valid frame commits
`timescale 1ns/1ns
`include "dsw_defs.vh"
module dsw_receiver #(
    parameter CH = `DSW_CHANNELS,
    parameter VW = `DSW_VAL_W
) (
    // Clock and synchronous reset
    input wire clk_sys,
    input wire sys_rst,
    // Host pins, all asynchronous to clk_sys
    input wire frame_sel_n,
    input wire ser_clk,
    input wire ser_din,
    // Chain output towards a following device
    output reg ser_dout,
    // Converter bank as the analog side would see it
    output reg [CH*VW-1:0] chan_value,
    output reg [CH-1:0] chan_pdown,
    output reg [1:0] pdown_term,
    // Frame outcome, for whoever watches the link
    output reg word_strobe,
    output reg [`DSW_WORD_W-1:0] word_last,
    output reg frame_abort
);
    // Address/mode field codes, small decode of the command nibble
    localparam [3:0] CMD_ALL_SAME = 4'h8;
    localparam [3:0] CMD_WRM = 4'h9;
    localparam [3:0] CMD_PD_HIZ = 4'hd;
    localparam [3:0] CMD_PD_1K = 4'he;
    localparam [3:0] CMD_PD_100K = 4'hf;
    localparam [3:0] CMD_UPD = 4'ha;
    localparam [3:0] CMD_CHA_WRM = 4'hb;

    // Synchroniser outputs and one cycle of edge history
    wire [2:0] pins_s;
    reg sclk_d_r;
    reg sel_d_r;
    // Word in flight and the number of falls seen in this frame
    reg [`DSW_WORD_W-1:0] shift_r;
    reg [4:0] fall_cnt_r;
    // Deferred-write mode and the values held behind the outputs
    reg wrm_mode_r;
    reg [CH*VW-1:0] hold_r;

    // Pins come from another domain
    dsw_sync #(.W(3)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({frame_sel_n, ser_clk, ser_din}),
        .q(pins_s)
    );

    // Named pins and their edges; history resets to the idle levels, so no false edge
    wire sel_n_s = pins_s[2];
    wire sclk_s = pins_s[1];
    wire din_s = pins_s[0];
    wire sclk_fall = sclk_d_r & ~sclk_s;
    wire sel_rise = ~sel_d_r & sel_n_s;
    // Command nibble and value field of the word in flight
    wire [3:0] cmd = shift_r[`DSW_ADDR_MSB:`DSW_ADDR_LSB];
    wire [VW-1:0] val = shift_r[`DSW_DATA_MSB:`DSW_DATA_LSB];

    // Edge history of synchronised pins
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sclk_d_r <= 1'b1;
            sel_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            sel_d_r <= sel_n_s;
        end
    end

    // Shift register and edge count; the count saturates so long frames still commit
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            shift_r <= `DSW_WORD_RESET;
            fall_cnt_r <= 5'h00;
        end else if (sel_n_s) begin
            fall_cnt_r <= 5'h00;
        end else if (sclk_fall) begin
            shift_r <= {shift_r[`DSW_WORD_W-2:0], din_s};
            if (fall_cnt_r != `DSW_FALL_SAT) begin
                fall_cnt_r <= fall_cnt_r + 5'h01;
            end
        end
    end

    // Chain output; the old top bit leaves on every fall, so a following device
    // sees nothing it can use until more than 16 falls have passed
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ser_dout <= 1'b0;
        end else if (!sel_n_s && sclk_fall) begin
            ser_dout <= shift_r[`DSW_WORD_W-1];
        end
    end

    // Falls needed before a frame end commits instead of aborting
    function frame_long;
        input [4:0] falls;
        begin
            frame_long = (falls >= `DSW_COMMIT_EDGES);
        end
    endfunction

    // Value slot of one channel within a packed bank
    function [VW-1:0] slot_get;
        input [CH*VW-1:0] bank;
        input integer idx;
        begin
            slot_get = bank[idx*VW +: VW];
        end
    endfunction

    // The three power-down codes; their low bits choose the termination
    function is_pdown_cmd;
        input [3:0] code;
        begin
            is_pdown_cmd = (code == CMD_PD_HIZ) || (code == CMD_PD_1K) || (code == CMD_PD_100K);
        end
    endfunction

    // Exactly one outcome per frame end; the slot field names the channel written
    wire commit = sel_rise && frame_long(fall_cnt_r);
    wire frame_short = sel_rise && !frame_long(fall_cnt_r);
    wire [2:0] slot = cmd[2:0];

    reg [CH*VW-1:0] chan_value_nxt;
    reg [CH*VW-1:0] hold_nxt;
    reg [CH-1:0] pdown_nxt;
    reg [1:0] term_nxt;
    reg wrm_nxt;
    integer i;

    // Next state of the bank; idle and aborted cycles keep every value
    always @* begin
        chan_value_nxt = chan_value;
        hold_nxt = hold_r;
        pdown_nxt = chan_pdown;
        term_nxt = pdown_term;
        wrm_nxt = wrm_mode_r;
        i = 0;
        if (commit) begin
            if (!cmd[3]) begin
                // A channel write also wakes that channel from power-down
                hold_nxt[slot*VW +: VW] = val;
                pdown_nxt[slot] = 1'b0;
                if (!wrm_mode_r) begin
                    chan_value_nxt[slot*VW +: VW] = val;
                end
            end else if (is_pdown_cmd(cmd)) begin
                // Power-down adds to the mask; only a channel write clears a bit
                pdown_nxt = chan_pdown | val[CH-1:0];
                term_nxt = cmd[1:0];
            end else begin
                case (cmd)
                CMD_WRM: begin
                    wrm_nxt = 1'b1;
                end
                CMD_ALL_SAME: begin
                    wrm_nxt = 1'b0;
                end
                CMD_UPD: begin
                    // Mask bit i moves held value i to its output
                    for (i = 0; i < CH; i = i + 1) begin
                        if (val[i]) begin
                            chan_value_nxt[i*VW +: VW] = slot_get(hold_r, i);
                        end
                    end
                end
                CMD_CHA_WRM: begin
                    // Channel 0 takes the new value while the others release what they hold
                    for (i = 0; i < CH; i = i + 1) begin
                        chan_value_nxt[i*VW +: VW] = slot_get(hold_r, i);
                    end
                    chan_value_nxt[0 +: VW] = val;
                    hold_nxt[0 +: VW] = val;
                end
                default: begin
                    // Codes with no meaning here are taken and ignored
                    wrm_nxt = wrm_mode_r;
                end
                endcase
            end
        end
    end

    // Bank registers and the one-cycle outcome pulses; all plain registers,
    // so the outputs never glitch while a word is decoded
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            chan_value <= {CH*VW{1'b0}};
            hold_r <= {CH*VW{1'b0}};
            chan_pdown <= {CH{1'b0}};
            pdown_term <= 2'b00;
            wrm_mode_r <= 1'b0;
            word_strobe <= 1'b0;
            word_last <= `DSW_WORD_RESET;
            frame_abort <= 1'b0;
        end else begin
            chan_value <= chan_value_nxt;
            hold_r <= hold_nxt;
            chan_pdown <= pdown_nxt;
            pdown_term <= term_nxt;
            wrm_mode_r <= wrm_nxt;
            word_strobe <= commit;
            frame_abort <= frame_short;
            if (commit) begin
                word_last <= shift_r;
            end
        end
    end
endmodule

// file: src/dsw_defs.vh
`ifndef DSW_DEFS_VH
`define DSW_DEFS_VH
// Input word geometry
`define DSW_WORD_W 16
// Falling edges needed to commit a frame
`define DSW_COMMIT_EDGES 5'h10
// Falls counter ceiling, so overlong chained frames cannot wrap it
`define DSW_FALL_SAT 5'h1f
// Reset value of the shift register and the last committed word
`define DSW_WORD_RESET 16'h0000
// Word fields: mode/address nibble and 12-bit value
`define DSW_ADDR_MSB 15
`define DSW_ADDR_LSB 12
`define DSW_DATA_MSB 11
`define DSW_DATA_LSB 0
// Channel count and value width
`define DSW_CHANNELS 8
`define DSW_VAL_W 12
// Reset value of every channel
`define DSW_VAL_RESET 12'h000
`endif

// file: src/dsw_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser, one per bit
module dsw_sync #(
    parameter W = 3
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            // Select and clock pins idle high, so every bit resets there to avoid a false edge
            meta_r <= {W{1'b1}};
            q <= {W{1'b1}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: verification/dsw_receiver_props.sv
`timescale 1ns/1ns
module dsw_receiver_props #(
    parameter CH = 8,
    parameter VW = 12
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire frame_sel_n,
    input wire ser_clk,
    input wire ser_din,
    input wire ser_dout,
    input wire [CH*VW-1:0] chan_value,
    input wire [CH-1:0] chan_pdown,
    input wire [1:0] pdown_term,
    input wire word_strobe,
    input wire [15:0] word_last,
    input wire frame_abort
);
    reg [2:0] ck_r;
    reg [1:0] sl_r, dt_r;
    reg [15:0] sh_r;
    wire fall_w = ck_r[2:1] == 2'b10;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Shadow synchronisers, so bits are taken as the block takes them
    always @(posedge clk_sys) begin
        ck_r <= {ck_r[1:0], ser_clk};
        sl_r <= {sl_r[0], frame_sel_n};
        dt_r <= {dt_r[0], ser_din};
        if (fall_w && !sl_r[1])
            sh_r <= {sh_r[14:0], dt_r[1]};
    end
    word_match_a: assert property (word_strobe |-> word_last == sh_r)
        else $error("committed word differs from shifted bits");
    commit_time_a: assert property ($rose(frame_sel_n) |-> ##[3:5] (word_strobe || frame_abort))
        else $error("no outcome after frame end");
    one_outcome_a: assert property (!(word_strobe && frame_abort))
        else $error("commit and abort together");
    abort_keeps_a: assert property (frame_abort |-> $stable(chan_value) && $stable(word_last))
        else $error("abort changed state");
    hold_values_a: assert property (!word_strobe |-> $stable(chan_value) && $stable(chan_pdown))
        else $error("state changed without commit");
    reset_zero_a: assert property ($fell(sys_rst) |-> chan_value == '0 && chan_pdown == '0)
        else $error("outputs not zero after reset");
    reset_quiet_a: assert property ($fell(sys_rst) |-> (!word_strobe && !frame_abort) [*4])
        else $error("outcome pulse right after reset");
    chain_fall_a: assert property ($changed(ser_dout) |-> fall_w || $past(fall_w) || $past(fall_w, 2))
        else $error("chain output moved without clock fall");
endmodule

// file: verification/dsw_host_model.sv
`timescale 1ns/1ns
module dsw_host_model (
    input wire clk_sys,
    output reg frame_sel_n,
    output reg ser_clk,
    output reg ser_din,
    input wire ser_dout
);
    reg [31:0] cap_r;
    // Clock idles high; data is released to its inverse between frames
    initial begin
        frame_sel_n = 1'b1;
        ser_clk = 1'b1;
        ser_din = 1'b0;
    end
    task send(input [31:0] w, input integer n);
        integer i;
        begin
            frame_sel_n <= 1'b0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                ser_din <= w[i];
                repeat (4) @(posedge clk_sys);
                cap_r <= {cap_r[30:0], ser_dout}; // Chain bit, settled long since
                ser_clk <= 1'b0;
                repeat (4) @(posedge clk_sys);
                ser_clk <= 1'b1;
            end
            repeat (4) @(posedge clk_sys);
            cap_r <= {cap_r[30:0], ser_dout};
            frame_sel_n <= 1'b1;
            ser_din <= ~w[0];
        end
    endtask
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg st_r, ab_r;
    wire frame_sel_n, ser_clk, ser_din, ser_dout, word_strobe, frame_abort;
    wire [95:0] chan_value;
    wire [7:0] chan_pdown;
    wire [1:0] pdown_term;
    wire [15:0] word_last;
    integer failures = 0;
    integer comparisons = 0;
    integer cycles = 0;
    always #5 clk_sys = ~clk_sys;
    dsw_host_model i_host (.clk_sys(clk_sys), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
        .ser_din(ser_din), .ser_dout(ser_dout));
    dsw_receiver i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
        .ser_din(ser_din), .ser_dout(ser_dout), .chan_value(chan_value), .chan_pdown(chan_pdown),
        .pdown_term(pdown_term), .word_strobe(word_strobe), .word_last(word_last), .frame_abort(frame_abort));
    task chk(input string nm, input [95:0] e, input [95:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Send a frame, watch the pulses mid-cycle, end on a rising edge for the next one
    task frame(input [31:0] w, input integer n);
        begin
            st_r = 1'b0;
            ab_r = 1'b0;
            i_host.send(w, n);
            repeat (12) begin
                @(negedge clk_sys);
                st_r = st_r | word_strobe;
                ab_r = ab_r | frame_abort;
            end
            @(posedge clk_sys);
        end
    endtask
    task t_write;
        begin
            chk("reset value", 96'h0, chan_value);
            frame(32'h0000_8000, 16);
            frame(32'h0000_3A5C, 16);
            chk("strobe", 1'b1, st_r);
            chk("word", 16'h3A5C, word_last);
            chk("ch3", 96'hA5C << 36, chan_value);
        end
    endtask
    task t_abort;
        begin
            frame(32'h0000_7123, 15);
            chk("abort", {1'b1, 1'b0}, {ab_r, st_r});
            chk("kept", 16'h3A5C, word_last);
            chk("kept ch3", 96'hA5C << 36, chan_value);
        end
    endtask
    task t_chain;
        begin
            frame(32'h2345_D001, 32);
            chk("last 16", 16'hD001, word_last);
            chk("pdown", 10'h005, {chan_pdown, pdown_term});
            chk("chain out", 16'h2345, i_host.cap_r[15:0]);
        end
    endtask
    // Deferred writes, masked update, channel 0 write that releases the others, other power-down codes
    task t_modes;
        begin
            frame(32'h0000_9000, 16);
            frame(32'h0000_5123, 16);
            chk("deferred", 96'hA5C << 36, chan_value);
            frame(32'h0000_A020, 16);
            chk("update", (96'h123 << 60) | (96'hA5C << 36), chan_value);
            frame(32'h0000_B456, 16);
            chk("ch0 update", (96'h123 << 60) | (96'hA5C << 36) | 96'h456, chan_value);
            frame(32'h0000_F0F0, 16);
            chk("pdown far", 10'h3C7, {chan_pdown, pdown_term});
            frame(32'h0000_4777, 16);
            frame(32'h0000_E002, 16);
            chk("pdown mid", 10'h38E, {chan_pdown, pdown_term});
            chk("held ch4", (96'h123 << 60) | (96'hA5C << 36) | 96'h456, chan_value);
        end
    endtask
    task print_verdict;
        begin
            $display("Checks %0d mismatches %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_write;
        t_abort;
        t_chain;
        t_modes;
        print_verdict;
    end
    // Hang guard, well past the roughly 1700 cycles the frames need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            print_verdict;
        end
    end
endmodule
bind dsw_receiver dsw_receiver_props #(.CH(CH), .VW(VW)) i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .frame_sel_n(frame_sel_n), .ser_clk(ser_clk), .ser_din(ser_din), .ser_dout(ser_dout),
    .chan_value(chan_value), .chan_pdown(chan_pdown), .pdown_term(pdown_term), .word_strobe(word_strobe),
    .word_last(word_last), .frame_abort(frame_abort));
